// *** lies_event_reg.sv ***
// Interrupt event register with set/clear access, bits 29 and 27 to 18
`timescale 1ns/100ps
`default_nettype none
module lies_event_reg #(
    parameter int CYCLE_LIMIT = lies_pkg::CYCLE_LIMIT_CYC,
    parameter int CTX_COUNT = 4
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_irq,
    output logic o_cycle_master_enable,
    output logic o_late_ack_event_enable,
    input wire logic i_rx_fifo_pending,
    input wire logic i_phys_resp_busy,
    input wire logic i_tardy_ack_sent,
    input wire logic i_xcvr_byte_valid,
    input wire logic [7:0] i_xcvr_byte,
    input wire logic i_cycle_start_tx,
    input wire logic i_subaction_gap_end,
    input wire logic [CTX_COUNT-1:0] i_ctx_dead,
    input wire logic [CTX_COUNT-1:0] i_ctx_irq_src,
    output logic [CTX_COUNT-1:0] o_ctx_irq,
    input wire logic i_cycle_start_rx,
    input wire logic [6:0] i_rx_second_count_field,
    input wire logic [12:0] i_rx_subsecond_cycle_field,
    input wire logic [6:0] i_second_count_field,
    input wire logic [12:0] i_subsecond_cycle_field,
    input wire logic i_arb_reset_gap,
    input wire logic i_xcvr_status_req,
    input wire logic i_reg_access_timeout
);
    logic [31:0] event_q;
    logic [31:0] mask_q;
    logic [31:0] masked;
    logic [31:0] hw_level;
    logic [31:0] hw_level_q;
    logic [31:0] hw_rise;
    logic [31:0] set_w;
    logic [31:0] clr_w;
    logic [7:0] xcvr_byte_q;
    logic cm_en_q;
    logic la_en_q;
    logic [15:0] ovr_cnt_q;
    logic ovr_run_q;
    logic ovr_hit;
    logic seen_start_q;
    logic gap_after_q;
    logic sec6_q;
    logic cyc0_q;
    logic tick64;
    logic new_cycle;
    logic missed;
    logic mismatch;
    logic cs_any;
    logic [31:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////
    // Cycle timing detectors
    assign tick64 = i_second_count_field[6] != sec6_q;
    assign new_cycle = i_subsecond_cycle_field[0] != cyc0_q;
    assign cs_any = i_cycle_start_tx | i_cycle_start_rx;
    assign mismatch = i_cycle_start_rx &&
        (i_rx_second_count_field != i_second_count_field ||
         i_rx_subsecond_cycle_field != i_subsecond_cycle_field);
    // Missed at next tick with no start, or predicted by gap/arb reset
    assign missed = (new_cycle && !seen_start_q && !cs_any) ||
        (gap_after_q && i_subaction_gap_end && !cs_any) ||
        (!seen_start_q && i_arb_reset_gap && !cs_any);
    assign ovr_hit = ovr_run_q && cm_en_q && ovr_cnt_q >= 16'(CYCLE_LIMIT);

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            sec6_q <= 1'b0;
            cyc0_q <= 1'b0;
        end else begin
            sec6_q <= i_second_count_field[6];
            cyc0_q <= i_subsecond_cycle_field[0];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            seen_start_q <= 1'b1;
            gap_after_q <= 1'b0;
        end else if (new_cycle) begin
            seen_start_q <= cs_any;
            gap_after_q <= !cs_any;
        end else begin
            if (cs_any) begin
                seen_start_q <= 1'b1;
            end
            if (cs_any || i_subaction_gap_end) begin
                gap_after_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            ovr_run_q <= 1'b0;
            ovr_cnt_q <= 16'h0000;
        end else if (i_cycle_start_tx) begin
            ovr_run_q <= 1'b1;
            ovr_cnt_q <= 16'h0000;
        end else if (i_subaction_gap_end || ovr_hit) begin
            ovr_run_q <= 1'b0;
        end else if (ovr_run_q && ovr_cnt_q != 16'hFFFF) begin
            ovr_cnt_q <= ovr_cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event sources and edges
    always_comb begin
        hw_level = 32'h00000000;
        hw_level[lies_pkg::BIT_LATE_ACK] = la_en_q &&
            (i_rx_fifo_pending || i_phys_resp_busy || i_tardy_ack_sent);
        hw_level[lies_pkg::BIT_XCVR_BYTE] = i_xcvr_byte_valid;
        hw_level[lies_pkg::BIT_OVERRUN] = ovr_hit;
        hw_level[lies_pkg::BIT_FATAL] = |i_ctx_dead;
        hw_level[lies_pkg::BIT_MISMATCH] = mismatch;
        hw_level[lies_pkg::BIT_MISSED] = missed;
        hw_level[lies_pkg::BIT_TICK64] = tick64;
        hw_level[lies_pkg::BIT_NEW_CYCLE] = new_cycle;
        hw_level[lies_pkg::BIT_XCVR_REQ] = i_xcvr_status_req;
        hw_level[lies_pkg::BIT_REG_TIMEOUT] = i_reg_access_timeout;
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            hw_level_q <= 32'h00000000;
        end else begin
            hw_level_q <= hw_level;
        end
    end

    // Soft bit has no entry in hw_level, so only writes touch it
    assign hw_rise = hw_level & ~hw_level_q;
    assign set_w = (i_wr && i_addr == lies_pkg::OFS_EVENT_SET) ? i_wdata : 32'h00000000;
    assign clr_w = (i_wr && i_addr == lies_pkg::OFS_EVENT_CLEAR) ? i_wdata : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////
    // Event storage; set beats clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            event_q <= lies_pkg::EVENT_RESET;
        end else begin
            event_q <= ((event_q & ~clr_w) | set_w | hw_rise) & lies_pkg::EVENT_IMPL_MASK;
        end
    end

    // Contexts that died stay quiet while the fatal bit is up
    assign o_ctx_irq = i_ctx_irq_src &
        ~(i_ctx_dead & {CTX_COUNT{event_q[lies_pkg::BIT_FATAL]}});

    ////////////////////////////////////////////////////////////////////////
    // Control registers
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            mask_q <= lies_pkg::MASK_RESET;
            la_en_q <= lies_pkg::LINK_CTRL_RESET[lies_pkg::BIT_LATE_ACK_EN];
            cm_en_q <= lies_pkg::LINK_CTRL_RESET[lies_pkg::BIT_CYCLE_MASTER];
        end else begin
            if (i_wr && i_addr == lies_pkg::OFS_EVENT_MASK) begin
                mask_q <= i_wdata;
            end
            if (i_wr && i_addr == lies_pkg::OFS_LINK_CTRL) begin
                la_en_q <= i_wdata[lies_pkg::BIT_LATE_ACK_EN];
            end
            if (ovr_hit) begin
                cm_en_q <= 1'b0;
            end else if (i_wr && i_addr == lies_pkg::OFS_LINK_CTRL) begin
                cm_en_q <= i_wdata[lies_pkg::BIT_CYCLE_MASTER];
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            xcvr_byte_q <= 8'h00;
        end else if (i_xcvr_byte_valid) begin
            xcvr_byte_q <= i_xcvr_byte;
        end
    end

    assign o_cycle_master_enable = cm_en_q;
    assign o_late_ack_event_enable = la_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Read path
    assign masked = event_q & mask_q & lies_pkg::EVENT_IMPL_MASK;
    assign o_irq = |masked;

    always_comb begin
        rdata_d = 32'h00000000;
        if (i_rd) begin
            unique case (i_addr)
                lies_pkg::OFS_EVENT_SET, lies_pkg::OFS_EVENT_CLEAR: rdata_d = masked;
                lies_pkg::OFS_EVENT_MASK: rdata_d = mask_q;
                lies_pkg::OFS_LINK_CTRL: rdata_d = {30'h00000000, cm_en_q, la_en_q};
                lies_pkg::OFS_XCVR_DATA: rdata_d = {8'h00, xcvr_byte_q, 16'h0000};
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= 32'h00000000;
        end else begin
            o_rdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software set and clear checks

    a_set_write_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr && i_addr == lies_pkg::OFS_EVENT_SET && i_wdata[lies_pkg::BIT_SOFT])
        |=> event_q[lies_pkg::BIT_SOFT]) else $error("set write lost");

    a_clear_only_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        ($fell(event_q[lies_pkg::BIT_NEW_CYCLE])) |->
        $past(i_wr && i_addr == lies_pkg::OFS_EVENT_CLEAR && i_wdata[lies_pkg::BIT_NEW_CYCLE]))
        else $error("bit cleared without clear write");

    a_clear_write_clears: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr && i_addr == lies_pkg::OFS_EVENT_CLEAR && i_wdata[lies_pkg::BIT_SOFT])
        |=> !event_q[lies_pkg::BIT_SOFT]) else $error("clear write lost");

    a_zero_write_keeps: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr && i_addr == lies_pkg::OFS_EVENT_CLEAR && !i_wdata[lies_pkg::BIT_SOFT])
        |=> $stable(event_q[lies_pkg::BIT_SOFT]))
        else $error("zero clear changed bit");

    a_zero_set_keeps: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr && i_addr == lies_pkg::OFS_EVENT_SET && !i_wdata[lies_pkg::BIT_SOFT])
        |=> $stable(event_q[lies_pkg::BIT_SOFT]))
        else $error("zero set changed bit");

    a_soft_no_hw: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        $rose(event_q[lies_pkg::BIT_SOFT]) |-> $past(i_wr && i_addr == lies_pkg::OFS_EVENT_SET))
        else $error("soft bit set by hardware");

    ////////////////////////////////////////////////////////////////////////
    // Hardware source checks

    a_late_ack_gate: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        ($rose(event_q[lies_pkg::BIT_LATE_ACK]) && !$past(set_w[lies_pkg::BIT_LATE_ACK]))
        |-> $past(la_en_q)) else $error("late ack without enable");

    a_late_ack_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (hw_level[lies_pkg::BIT_LATE_ACK] && !hw_level_q[lies_pkg::BIT_LATE_ACK])
        |=> event_q[lies_pkg::BIT_LATE_ACK]) else $error("late ack event lost");

    a_late_ack_en_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr && i_addr == lies_pkg::OFS_LINK_CTRL)
        |=> la_en_q == $past(i_wdata[lies_pkg::BIT_LATE_ACK_EN])) else $error("late ack enable not written");

    a_xcvr_byte_kept: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_xcvr_byte_valid |=> xcvr_byte_q == $past(i_xcvr_byte))
        else $error("transceiver byte not kept");

    a_xcvr_bit_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_xcvr_byte_valid && !hw_level_q[lies_pkg::BIT_XCVR_BYTE])
        |=> event_q[lies_pkg::BIT_XCVR_BYTE]) else $error("byte event lost");

    a_overrun_needs_cm: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        ($rose(event_q[lies_pkg::BIT_OVERRUN]) && !$past(set_w[lies_pkg::BIT_OVERRUN]))
        |-> $past(cm_en_q)) else $error("overrun without cycle master");

    a_overrun_clears_cm: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        ovr_hit |=> (!cm_en_q && event_q[lies_pkg::BIT_OVERRUN]))
        else $error("overrun handling wrong");

    a_cm_cleared_why: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        $fell(cm_en_q) |-> $past(ovr_hit || (i_wr && i_addr == lies_pkg::OFS_LINK_CTRL)))
        else $error("cycle master dropped without cause");

    a_fatal_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        ((|i_ctx_dead) && !hw_level_q[lies_pkg::BIT_FATAL])
        |=> event_q[lies_pkg::BIT_FATAL]) else $error("fatal event lost");

    a_fatal_blocks: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        event_q[lies_pkg::BIT_FATAL] |-> ((o_ctx_irq & i_ctx_dead) == '0))
        else $error("dead context interrupt passed");

    a_mismatch_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (mismatch && !hw_level_q[lies_pkg::BIT_MISMATCH])
        |=> event_q[lies_pkg::BIT_MISMATCH]) else $error("mismatch event lost");

    a_missed_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (missed && !hw_level_q[lies_pkg::BIT_MISSED])
        |=> event_q[lies_pkg::BIT_MISSED]) else $error("missed cycle event lost");

    a_tick64_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (tick64 && !hw_level_q[lies_pkg::BIT_TICK64])
        |=> event_q[lies_pkg::BIT_TICK64]) else $error("tick event lost");

    a_tick_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (new_cycle && !hw_level_q[lies_pkg::BIT_NEW_CYCLE]) |=> event_q[lies_pkg::BIT_NEW_CYCLE])
        else $error("new cycle missed");

    a_xcvr_req_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_xcvr_status_req && !hw_level_q[lies_pkg::BIT_XCVR_REQ])
        |=> event_q[lies_pkg::BIT_XCVR_REQ]) else $error("status request lost");

    a_timeout_sets: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_reg_access_timeout && !hw_level_q[lies_pkg::BIT_REG_TIMEOUT])
        |=> event_q[lies_pkg::BIT_REG_TIMEOUT]) else $error("access timeout lost");

    ////////////////////////////////////////////////////////////////////////
    // Read path checks

    a_read_masked: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_rd && i_addr == lies_pkg::OFS_EVENT_SET) |=> o_rdata == $past(event_q & mask_q))
        else $error("read not masked");

    a_clear_read_same: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_rd && i_addr == lies_pkg::OFS_EVENT_CLEAR) |=> o_rdata == $past(event_q & mask_q))
        else $error("clear address read wrong");

    a_mask_write: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_wr && i_addr == lies_pkg::OFS_EVENT_MASK) |=> mask_q == $past(i_wdata))
        else $error("mask write lost");

    a_rdata_idle: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        !i_rd |=> o_rdata == 32'h00000000) else $error("read data not idle");

    a_reserved_zero: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_rd && i_addr == lies_pkg::OFS_EVENT_CLEAR) |=> (o_rdata[31:30] == 2'h0 && !o_rdata[28]))
        else $error("reserved bit nonzero");

    a_reserved_low: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_rd && i_addr == lies_pkg::OFS_EVENT_SET) |=> (o_rdata[14:10] == 5'h00 && !o_rdata[28]))
        else $error("reserved low bits nonzero");

    a_ctrl_readback: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_rd && i_addr == lies_pkg::OFS_LINK_CTRL) |=> o_rdata[1:0] == $past({cm_en_q, la_en_q}))
        else $error("control readback wrong");

    a_xcvr_readback: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        (i_rd && i_addr == lies_pkg::OFS_XCVR_DATA) |=> o_rdata[23:16] == $past(xcvr_byte_q))
        else $error("transceiver byte readback wrong");

    a_irq_level: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        o_irq == ((event_q & mask_q) != 32'h00000000)) else $error("irq mismatch");
endmodule
`default_nettype wire

// *** lies_pkg.sv ***
// Constants for the link interrupt event set/clear block
// Contract
// - Source rising edge or set write sets
// - Only clear-address write of one clears
// - Read returns events ANDed with mask
// - Bits 31 and 30 read zero
// - Bit 28 reads zero
// - Software interrupt bit has no source
// - Late ack needs enable bit set
// - Late ack qualifying conditions ORed
// - Transceiver byte sets bit, byte readable
// - Cycle overrun sets bit when master
// - Cycle overrun clears cycle master enable
// - Subunit halt sets fatal error bit
// - Fatal error blocks causing context interrupts
// - Cycle start time mismatch sets bit
// - No cycle start between ticks: missed
// - Missed cycle may be predicted early
// - Seconds bit six change sets tick
// - Cycle count lsb toggle sets event
// - Transceiver status request sets bit
// - Register access timeout sets bit
// - Bits 31,29,28,27,18 reset zero
// - Bits 14 to 10 read zero
package lies_pkg;
    localparam logic [7:0] OFS_EVENT_SET = 8'h80;
    localparam logic [7:0] OFS_EVENT_CLEAR = 8'h84;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h88;
    localparam logic [7:0] OFS_LINK_CTRL = 8'h8C;
    localparam logic [7:0] OFS_XCVR_DATA = 8'h90;
    localparam int BIT_SOFT = 29;
    localparam int BIT_LATE_ACK = 27;
    localparam int BIT_XCVR_BYTE = 26;
    localparam int BIT_OVERRUN = 25;
    localparam int BIT_FATAL = 24;
    localparam int BIT_MISMATCH = 23;
    localparam int BIT_MISSED = 22;
    localparam int BIT_TICK64 = 21;
    localparam int BIT_NEW_CYCLE = 20;
    localparam int BIT_XCVR_REQ = 19;
    localparam int BIT_REG_TIMEOUT = 18;
    localparam int BIT_LATE_ACK_EN = 0;
    localparam int BIT_CYCLE_MASTER = 1;
    localparam logic [31:0] EVENT_IMPL_MASK = 32'h2FFC0000;
    localparam logic [31:0] EVENT_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [1:0] LINK_CTRL_RESET = 2'h0;
    localparam int CYCLE_LIMIT_US = 125;
    localparam int CLK_MHZ = 10;
    localparam int CYCLE_LIMIT_CYC = CYCLE_LIMIT_US * CLK_MHZ;
endpackage

// *** link_interrupt_event_set_clear_tb.sv ***
// Self-checking testbench for the interrupt event set/clear register
`timescale 1ns/100ps
`default_nettype none
module link_interrupt_event_set_clear_tb;
    localparam int CTX_COUNT = 4;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic i_mclk, i_rstn, i_wr, i_rd, o_irq, o_cycle_master_enable, o_late_ack_event_enable;
    logic [7:0] i_addr, i_xcvr_byte;
    logic [31:0] i_wdata, o_rdata, rd, ev, m, s, c;
    logic i_rx_fifo_pending, i_phys_resp_busy, i_tardy_ack_sent, i_xcvr_byte_valid;
    logic i_cycle_start_tx, i_subaction_gap_end, i_cycle_start_rx, i_arb_reset_gap;
    logic i_xcvr_status_req, i_reg_access_timeout;
    logic [CTX_COUNT-1:0] i_ctx_dead, i_ctx_irq_src, o_ctx_irq;
    logic [6:0] i_rx_second_count_field, i_second_count_field;
    logic [12:0] i_rx_subsecond_cycle_field, i_subsecond_cycle_field;
    integer seed = 32'h81706BF6;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;

    lies_event_reg #(.CYCLE_LIMIT(20), .CTX_COUNT(CTX_COUNT)) uut (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_irq(o_irq), .o_cycle_master_enable(o_cycle_master_enable),
        .o_late_ack_event_enable(o_late_ack_event_enable), .i_rx_fifo_pending(i_rx_fifo_pending),
        .i_phys_resp_busy(i_phys_resp_busy), .i_tardy_ack_sent(i_tardy_ack_sent),
        .i_xcvr_byte_valid(i_xcvr_byte_valid), .i_xcvr_byte(i_xcvr_byte),
        .i_cycle_start_tx(i_cycle_start_tx), .i_subaction_gap_end(i_subaction_gap_end),
        .i_ctx_dead(i_ctx_dead), .i_ctx_irq_src(i_ctx_irq_src), .o_ctx_irq(o_ctx_irq),
        .i_cycle_start_rx(i_cycle_start_rx), .i_rx_second_count_field(i_rx_second_count_field),
        .i_rx_subsecond_cycle_field(i_rx_subsecond_cycle_field), .i_second_count_field(i_second_count_field),
        .i_subsecond_cycle_field(i_subsecond_cycle_field), .i_arb_reset_gap(i_arb_reset_gap),
        .i_xcvr_status_req(i_xcvr_status_req), .i_reg_access_timeout(i_reg_access_timeout)
    );

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Bench functions and bus tasks
    function automatic logic [31:0] exp_rd(input logic [31:0] e, input logic [31:0] k);
        return e & k & lies_pkg::EVENT_IMPL_MASK;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 rd = o_rdata;
    endtask

    task automatic bit_is(input logic [31:0] bits, input logic on);
        rdr(8'h80);
        chk(rd & bits, on ? bits : 32'h0);
    endtask

    task automatic summarize();
        if (n_fail == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {i_wr, i_rd, i_rx_fifo_pending, i_phys_resp_busy, i_tardy_ack_sent, i_xcvr_byte_valid} = '0;
        {i_cycle_start_tx, i_subaction_gap_end, i_cycle_start_rx, i_arb_reset_gap} = '0;
        {i_xcvr_status_req, i_reg_access_timeout, i_ctx_dead, i_ctx_irq_src} = '0;
        {i_rx_second_count_field, i_second_count_field} = '0;
        {i_rx_subsecond_cycle_field, i_subsecond_cycle_field} = '0;
        {i_addr, i_xcvr_byte, i_wdata} = '0;
        i_rstn = 1'b0;
        repeat (2) @(posedge i_mclk);
        i_rstn <= 1'b1;
        wr(8'h88, ALL);
        rdr(8'h80);
        chk(rd, 32'h0);
        rdr(8'hFC);
        chk(rd, 32'h0);
        ev = '0;
        for (int k = 0; k < 24; k++) begin
            m = (k == 0) ? ALL : $random(seed);
            s = (k == 0) ? ALL : $random(seed);
            c = $random(seed);
            wr(8'h88, m);
            wr(8'h80, s);
            ev = ev | s;
            rdr(8'h80);
            chk(rd, exp_rd(ev, m));
            chk(32'(o_irq), 32'(|exp_rd(ev, m)));
            wr(8'h84, c);
            ev = ev & ~c;
            rdr(8'h84);
            chk(rd, exp_rd(ev, m));
        end
        wr(8'h88, ALL);
        wr(8'h84, ALL);
        @(posedge i_mclk);
        {i_xcvr_status_req, i_reg_access_timeout, i_xcvr_byte_valid} <= 3'h7;
        i_xcvr_byte <= s[15:8];
        @(posedge i_mclk);
        {i_xcvr_status_req, i_reg_access_timeout, i_xcvr_byte_valid} <= 3'h0;
        bit_is(32'h040C0000, 1'b1);
        rdr(8'h90);
        chk(32'(rd[23:16]), 32'(s[15:8]));
        wr(8'h84, ALL);
        @(posedge i_mclk) i_rx_fifo_pending <= 1'b1;
        bit_is(32'h08000000, 1'b0);
        @(posedge i_mclk) i_rx_fifo_pending <= 1'b0;
        wr(8'h8C, 32'h1);
        chk(32'(o_late_ack_event_enable), 32'h1);
        for (int k = 0; k < 3; k++) begin
            wr(8'h84, ALL);
            @(posedge i_mclk) {i_tardy_ack_sent, i_phys_resp_busy, i_rx_fifo_pending} <= 3'(1 << k);
            @(posedge i_mclk) {i_tardy_ack_sent, i_phys_resp_busy, i_rx_fifo_pending} <= 3'h0;
            bit_is(32'h08000000, 1'b1);
        end
        wr(8'h84, ALL);
        @(posedge i_mclk) {i_ctx_dead, i_ctx_irq_src} <= 8'h1F;
        bit_is(32'h01000000, 1'b1);
        chk(32'(o_ctx_irq), 32'hE);
        wr(8'h84, 32'h01000000);
        bit_is(32'h01000000, 1'b0);
        chk(32'(o_ctx_irq), 32'hF);
        for (int k = 0; k < 2; k++) begin
            wr(8'h84, ALL);
            @(posedge i_mclk) {i_cycle_start_rx, i_rx_second_count_field} <= {1'b1, 7'(k)};
            @(posedge i_mclk) i_cycle_start_rx <= 1'b0;
            bit_is(32'h00800000, k[0]);
        end
        wr(8'h84, ALL);
        @(posedge i_mclk) {i_second_count_field, i_subsecond_cycle_field} <= {7'h40, 13'h1};
        @(posedge i_mclk) i_arb_reset_gap <= 1'b1;
        @(posedge i_mclk) i_arb_reset_gap <= 1'b0;
        bit_is(32'h00700000, 1'b1);
        wr(8'h84, ALL);
        @(posedge i_mclk) i_subsecond_cycle_field <= 13'h0;
        @(posedge i_mclk);
        bit_is(32'h00500000, 1'b1);
        @(posedge i_mclk) i_cycle_start_rx <= 1'b1;
        @(posedge i_mclk) i_cycle_start_rx <= 1'b0;
        @(posedge i_mclk) i_subsecond_cycle_field <= 13'h1;
        wr(8'h84, ALL);
        bit_is(32'h00400000, 1'b0);
        @(posedge i_mclk) i_subaction_gap_end <= 1'b1;
        @(posedge i_mclk) i_subaction_gap_end <= 1'b0;
        bit_is(32'h00400000, 1'b1);
        wr(8'h8C, 32'h2);
        chk(32'(o_cycle_master_enable), 32'h1);
        wr(8'h84, ALL);
        @(posedge i_mclk) i_cycle_start_tx <= 1'b1;
        @(posedge i_mclk) i_cycle_start_tx <= 1'b0;
        repeat (10) @(posedge i_mclk);
        bit_is(32'h02000000, 1'b0);
        repeat (15) @(posedge i_mclk);
        bit_is(32'h02000000, 1'b1);
        chk(32'(o_cycle_master_enable), 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
